//--- test/gioif_field.sv
// Field-side model: switch contacts on inputs, loads on outputs
`timescale 1ns/1ps
module gioif_field (
  // Switch states, one bit per input channel
  input  wire logic [gioif_pkg::IN_W-1:0]  onMask,
  // Output transistor pins from the block
  input  wire logic [gioif_pkg::OUT_W-1:0] outPinLevel,
  // Pin levels towards the block, decoded load states
  output logic      [gioif_pkg::IN_W-1:0]  inPinLevel,
  output logic      [gioif_pkg::OUT_W-1:0] outOn
);
  import gioif_pkg::*;
  assign inPinLevel = ~onMask;
  assign outOn = ~outPinLevel;
endmodule

//--- test/gioif_top_chk.sv
// Concurrent checks on the group I/O block ports
`timescale 1ns/1ps
module gioif_top_chk (
  // Clock and reset
  input wire logic                          clk_sys,
  input wire logic                          rst,
  // Host access
  input wire gioif_pkg::gioif_req_t         ioReq,
  input wire logic [gioif_pkg::GROUP_W-1:0] ioRdData,
  input wire logic                          ioRdValid,
  // Field pins
  input wire logic [gioif_pkg::IN_W-1:0]    inPinLevel,
  input wire logic [gioif_pkg::OUT_W-1:0]   outPinLevel
);
  import gioif_pkg::*;
  logic [PTR_W-1:0] ptr_r;
  logic [SET_W-1:0] set_r;
  logic [SET_W-1:0] set_nxt;
  // Request decode
  wire atVal = ioReq.addr == OFS_GROUP_VALUE;
  wire atIn = ioReq.addr <= OFS_IN_LAST;
  wire atOut = ioReq.addr >= OFS_OUT_FIRST && ioReq.addr <= OFS_OUT_LAST;
  wire atSet = ioReq.addr == OFS_DEBOUNCE_SET;
  // Out-of-range settings clamp, matching the chosen behaviour
  assign set_nxt = ioReq.data[4:0] > SET_MAX ? SET_MAX : ioReq.data[4:0];
  // Shadow pointer and setting so checks know the selected group
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ptr_r <= PTR_RESET;
      set_r <= SET_RESET;
    end else begin
      if (ioReq.wr && ioReq.addr == OFS_GROUP_PTR) ptr_r <= ioReq.data[2:0];
      if (ioReq.wr && atSet) set_r <= set_nxt;
    end
  end
  // Active-high view of one byte of a low-active pin vector
  function automatic logic [7:0] onBits(logic [31:0] v, logic [1:0] g);
    return ~v[int'(g)*GROUP_W +: GROUP_W];
  endfunction
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Pins stable long enough to cross the synchroniser
  sequence pinsQuiet;
    (set_r == SET_BYPASS && $stable(inPinLevel)) [*4];
  endsequence
  chk_read_valid_pulse: assert property (ioReq.rd |=> ioRdValid)
    else $error("read strobe without answer");
  chk_no_stray_valid: assert property (!ioReq.rd |=> !ioRdValid)
    else $error("answer without read strobe");
  chk_reset_outputs_off: assert property (disable iff (1'b0) rst |=> &outPinLevel)
    else $error("outputs not off after reset");
  // indirect write drives the pointed group
  chk_group_write_out: assert property (ioReq.wr && atVal && ptr_r[2] |=>
    onBits(outPinLevel, $past(ptr_r[1:0])) == $past(ioReq.data))
    else $error("indirect write not on pins");
  // write to an input group changes nothing
  chk_input_write_ign: assert property (ioReq.wr && atVal && !ptr_r[2] |=>
    $stable(outPinLevel)) else $error("input group write changed outputs");
  chk_direct_write_out: assert property (ioReq.wr && atOut |=>
    onBits(outPinLevel, $past(ioReq.addr[1:0])) == $past(ioReq.data))
    else $error("direct write not on pins");
  chk_group_read_back: assert property (ioReq.rd && atVal && ptr_r[2] |=>
    ioRdData == onBits($past(outPinLevel), $past(ptr_r[1:0])))
    else $error("read-back differs from latch");
  chk_setting_read: assert property (ioReq.rd && atSet |=>
    ioRdData == {3'h0, set_r}) else $error("setting read-back wrong");
  chk_bypass_input: assert property (pinsQuiet ##0 ioReq.rd && atIn |=>
    ioRdData == onBits($past(inPinLevel), $past(ioReq.addr[1:0])))
    else $error("bypassed input read wrong");
endmodule
bind gioif_top gioif_top_chk i_chk (.clk_sys(clk_sys), .rst(rst), .ioReq(ioReq),
  .ioRdData(ioRdData), .ioRdValid(ioRdValid), .inPinLevel(inPinLevel),
  .outPinLevel(outPinLevel));

//--- test/test_gioif_top.sv
// Directed testbench for the group I/O and input filter block
`timescale 1ns/1ps
module test_gioif_top;
  import gioif_pkg::*;
  logic              clk_sys;
  logic              rst;
  gioif_req_t        ioReq;
  logic [7:0]        ioRdData;
  logic              ioRdValid;
  logic [IN_W-1:0]   inPinLevel;
  logic [IN_W-1:0]   onMask;
  logic [OUT_W-1:0]  outPinLevel;
  logic [OUT_W-1:0]  outOn;
  logic [OUT_W-1:0]  expOn;
  int                failures;
  int                checks_done;
  int                early;
  int                late;
  // Design and field model
  gioif_top i_dut (.clk_sys(clk_sys), .rst(rst), .ioReq(ioReq), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .inPinLevel(inPinLevel), .outPinLevel(outPinLevel));
  gioif_field i_field (.onMask(onMask), .outPinLevel(outPinLevel),
    .inPinLevel(inPinLevel), .outOn(outOn));
  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One-cycle write strobe, driven off the sampling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    ioReq = '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
    @(negedge clk_sys);
    ioReq = '0;
  endtask
  // Read answer is sampled in the cycle after the strobe
  task automatic rdChk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    ioReq = '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
    @(negedge clk_sys);
    ioReq = '0;
    compare("read valid", ioRdValid, 1'b1);
    compare(what, ioRdData, e);
  endtask
  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    ioReq = '0;
    onMask = 32'h81C3_5A0F;
    expOn = '0;
    failures = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    compare("outputs at reset", outOn, 32'h0000_0000);
    rdChk("setting at reset", OFS_DEBOUNCE_SET, 8'h00);
    // Pointer with junk upper bits still selects the low three
    for (int g = 4; g < 8; g++) begin
      wr(OFS_GROUP_PTR, 8'hF8 | 8'(g));
      wr(OFS_GROUP_VALUE, 8'h5A ^ 8'(g * 17));
      expOn[(g-4)*8 +: 8] = 8'h5A ^ 8'(g * 17);
      compare("group outputs", outOn, expOn);
      rdChk("indirect readback", OFS_GROUP_VALUE, expOn[(g-4)*8 +: 8]);
      rdChk("direct readback", 5'(g), expOn[(g-4)*8 +: 8]);
    end
    // Direct byte write lands in the same latch the pointer reaches
    wr(OFS_OUT_FIRST + 5'h01, 8'hC3);
    expOn[15:8] = 8'hC3;
    compare("direct write", outOn, expOn);
    wr(OFS_GROUP_PTR, 8'h05);
    rdChk("pointed after direct", OFS_GROUP_VALUE, 8'hC3);
    for (int g = 0; g < 4; g++) begin
      wr(OFS_GROUP_PTR, 8'(g));
      wr(OFS_GROUP_VALUE, 8'hFF);
      wr(5'(g), 8'hFF);
      compare("outputs kept", outOn, expOn);
      rdChk("indirect input", OFS_GROUP_VALUE, onMask[g*8 +: 8]);
      rdChk("direct input", 5'(g), onMask[g*8 +: 8]);
    end
    rdChk("pointer read", OFS_GROUP_PTR, 8'h00);
    rdChk("unmapped read", 5'h1F, 8'h00);
    // Every legal setting, then one with stray upper bits
    for (int s = 0; s <= 20; s++) begin
      wr(OFS_DEBOUNCE_SET, 8'(s));
      rdChk("setting", OFS_DEBOUNCE_SET, 8'(s));
    end
    wr(OFS_DEBOUNCE_SET, 8'hE3);
    rdChk("setting five bits", OFS_DEBOUNCE_SET, 8'h03);
    // Tick spacing 12 to 13 clocks; first tick may be partial
    for (int n = 1; n <= 3; n++) begin
      early = ((1 << n) - 1) * 12 - 4;
      late = (1 << n) * 13 + 6;
      wr(OFS_DEBOUNCE_SET, 8'(n));
      onMask = '0;
      repeat (late) @(negedge clk_sys);
      onMask = '1;
      repeat (early) @(negedge clk_sys);
      onMask = '0;
      repeat (late) @(negedge clk_sys);
      rdChk("glitch dropped", OFS_GROUP_FIRST, 8'h00);
      onMask = '1;
      repeat (early) @(negedge clk_sys);
      rdChk("before filter time", OFS_GROUP_FIRST, 8'h00);
      repeat (late - early) @(negedge clk_sys);
      for (int g = 0; g < 4; g++) begin
        rdChk("after filter time", 5'(g), 8'hFF);
      end
    end
    // Mid-run reset must clear written latches, setting and pointer
    @(negedge clk_sys) rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    compare("outputs after reset", outOn, 32'h0000_0000);
    rdChk("setting after reset", OFS_DEBOUNCE_SET, 8'h00);
    rdChk("pointer after reset", OFS_GROUP_VALUE, 8'hFF);
    report_and_stop();
  end
endmodule

//--- verilog/gioif_filter.sv
// Per-channel input synchroniser and common-time debounce filter
`timescale 1ns/1ps
module gioif_filter (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // Common controls
  input  wire logic                          tick,
  input  wire logic [gioif_pkg::SET_W-1:0]   setting,
  // Raw pins and filtered levels
  input  wire logic [gioif_pkg::IN_W-1:0]    pinLevel,
  output logic      [gioif_pkg::IN_W-1:0]    filtLevel
);
  import gioif_pkg::*;

  // Tick count that must elapse with a steady level: 2^setting
  logic [CNT_W-1:0] target;
  logic             bypass;
  assign target = CNT_ONE << setting;
  assign bypass = (setting == SET_BYPASS);

  genvar ch;
  generate
    for (ch = 0; ch < IN_W; ch++) begin : gChan
      logic             syncA_r;
      logic             syncB_r;
      logic             stable_r;
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;
      logic             differs;
      logic             expired;

      // sampled on bus clock; two flops since pins are asynchronous
      always_ff @(posedge clk_sys) begin
        syncA_r <= pinLevel[ch];
        syncB_r <= syncA_r;
      end

      assign differs = (syncB_r != stable_r);
      assign cnt_nxt = cnt_r + CNT_ONE;
      assign expired = tick && (cnt_nxt == target);

      // accept level after steady time; short glitches restart count
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          stable_r <= 1'b0;
          cnt_r    <= CNT_ZERO;
        end else if (bypass || !differs) begin
          stable_r <= syncB_r;
          cnt_r    <= CNT_ZERO;
        end else if (expired) begin
          stable_r <= syncB_r;
          cnt_r    <= CNT_ZERO;
        end else if (tick) begin
          cnt_r    <= cnt_nxt;
        end
      end

      // setting zero passes synchronised level straight through
      assign filtLevel[ch] = bypass ? syncB_r : stable_r;
    end
  endgenerate

endmodule

//--- verilog/gioif_pkg.sv
// Shared constants and types for the group I/O and input filter block
package gioif_pkg;

  // Port widths
  localparam int GROUP_W   = 8;
  localparam int IN_GROUPS = 4;
  localparam int OUT_GROUPS = 4;
  localparam int IN_W      = GROUP_W * IN_GROUPS;
  localparam int OUT_W     = GROUP_W * OUT_GROUPS;
  localparam int ADDR_W    = 5;
  localparam int PTR_W     = 3;
  localparam int SET_W     = 5;

  // I/O port offsets (byte addresses within the board window)
  localparam logic [ADDR_W-1:0] OFS_GROUP_FIRST  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_IN_LAST      = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_OUT_FIRST    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_OUT_LAST     = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_GROUP_VALUE  = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_GROUP_PTR    = 5'h0D;
  localparam logic [ADDR_W-1:0] OFS_DEBOUNCE_SET = 5'h0F;

  // Group numbering: pointer bit 2 marks an output group
  localparam int PTR_OUT_BIT = 2;

  // Reset values
  localparam logic [GROUP_W-1:0] OUT_RESET   = 8'h00;
  localparam logic [SET_W-1:0]   SET_RESET   = 5'h00;
  localparam logic [PTR_W-1:0]   PTR_RESET   = 3'h0;
  localparam logic [GROUP_W-1:0] READ_ZERO   = 8'h00;

  // Filter setting limits
  localparam logic [SET_W-1:0] SET_BYPASS = 5'h00;
  localparam logic [SET_W-1:0] SET_MAX    = 5'h14;

  // Time base: 16 MHz ticks derived from the 200 MHz system clock
  localparam int CLK_HZ      = 200_000_000;
  localparam int TBASE_HZ    = 16_000_000;
  localparam int TB_ACC_W    = 8;
  localparam logic [TB_ACC_W-1:0] TB_STEP = TB_ACC_W'(TBASE_HZ / 1_000_000);
  localparam logic [TB_ACC_W-1:0] TB_MOD  = TB_ACC_W'(CLK_HZ / 1_000_000);

  // Debounce tick counter must hold 2^20
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] CNT_ONE  = 21'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 21'h000000;

  // Host I/O request carrier
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [GROUP_W-1:0] data;
  } gioif_req_t;

endpackage

//--- verilog/gioif_top.sv
// Group-indexed I/O ports with output latches and debounced inputs
`timescale 1ns/1ps
module gioif_top (
  // Clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // Host I/O port access
  input  wire gioif_pkg::gioif_req_t          ioReq,
  output logic      [gioif_pkg::GROUP_W-1:0]  ioRdData,
  output logic                                ioRdValid,
  // Field pins
  input  wire logic [gioif_pkg::IN_W-1:0]     inPinLevel,
  output logic      [gioif_pkg::OUT_W-1:0]    outPinLevel
);
  import gioif_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------

  // Output latches, one byte per output group
  logic [GROUP_W-1:0] outLatch_r [OUT_GROUPS];
  logic [GROUP_W-1:0] outLatch_nxt [OUT_GROUPS];

  // Group pointer and debounce setting
  logic [PTR_W-1:0]   groupPtr_r;
  logic [PTR_W-1:0]   groupPtr_nxt;
  logic [SET_W-1:0]   debounceSet_r;
  logic [SET_W-1:0]   debounceSet_nxt;

  // Read answer
  logic [GROUP_W-1:0] rdData_r;
  logic [GROUP_W-1:0] rdData_nxt;
  logic               rdValid_r;

  // Time base accumulator
  logic [TB_ACC_W-1:0] tbAcc_r;
  logic [TB_ACC_W-1:0] tbAcc_nxt;
  logic [TB_ACC_W-1:0] tbSum;
  logic                tbTick;

  // Filtered input levels and active-high input bits
  logic [IN_W-1:0]     filtLevel;
  logic [IN_W-1:0]     inBits;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------

  // Direct group range and register offset checks
  logic hitInGroup;
  logic hitOutGroup;
  logic hitGroupValue;
  logic hitGroupPtr;
  logic hitDebounce;
  logic hitUnmapped;

  assign hitInGroup    = (ioReq.addr >= OFS_GROUP_FIRST) && (ioReq.addr <= OFS_IN_LAST);
  assign hitOutGroup   = (ioReq.addr >= OFS_OUT_FIRST) && (ioReq.addr <= OFS_OUT_LAST);
  assign hitGroupValue = (ioReq.addr == OFS_GROUP_VALUE);
  assign hitGroupPtr   = (ioReq.addr == OFS_GROUP_PTR);
  assign hitDebounce   = (ioReq.addr == OFS_DEBOUNCE_SET);
  assign hitUnmapped   = !(hitInGroup || hitOutGroup || hitGroupValue
                           || hitGroupPtr || hitDebounce);

  // Group index addressed directly (low three address bits)
  logic [PTR_W-1:0] directGroup;
  assign directGroup = ioReq.addr[PTR_W-1:0];

  // Output group index (low two bits of a group number)
  logic [1:0] directOutIdx;
  logic [1:0] ptrOutIdx;
  assign directOutIdx = directGroup[1:0];
  assign ptrOutIdx    = groupPtr_r[1:0];

  // Whether the pointer currently names an output group
  logic ptrIsOutput;
  assign ptrIsOutput = groupPtr_r[PTR_OUT_BIT];

  // Write strobes
  logic wrDirectOut;
  logic wrGroupValue;
  logic wrGroupPtr;
  logic wrDebounce;

  assign wrDirectOut  = ioReq.wr && hitOutGroup;
  // pointed input group blocks the indirect write
  assign wrGroupValue = ioReq.wr && hitGroupValue && ptrIsOutput;
  assign wrGroupPtr   = ioReq.wr && hitGroupPtr;
  assign wrDebounce   = ioReq.wr && hitDebounce;

  // ---------------------------------------------------------------
  // Group pointer
  // ---------------------------------------------------------------

  // only three bits are kept; upper written bits are dropped
  assign groupPtr_nxt = wrGroupPtr ? ioReq.data[PTR_W-1:0] : groupPtr_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      groupPtr_r <= PTR_RESET;
    end else begin
      groupPtr_r <= groupPtr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output latches
  // ---------------------------------------------------------------

  // Each output byte takes a direct write or an indirect write through the
  // pointer; both cannot arrive in one cycle since they use distinct offsets
  genvar og;
  generate
    for (og = 0; og < OUT_GROUPS; og++) begin : gOut
      logic selDirect;
      logic selIndirect;
      assign selDirect   = wrDirectOut && (directOutIdx == 2'(og));
      // indirect write lands in the pointed output group
      assign selIndirect = wrGroupValue && (ptrOutIdx == 2'(og));
      assign outLatch_nxt[og] = (selDirect || selIndirect) ? ioReq.data : outLatch_r[og];

      // reset clears outputs so every transistor starts off
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          outLatch_r[og] <= OUT_RESET;
        end else begin
          outLatch_r[og] <= outLatch_nxt[og];
        end
      end

      // bit one pulls the pin low, zero releases it high
      assign outPinLevel[og*GROUP_W +: GROUP_W] = ~outLatch_r[og];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Debounce setting
  // ---------------------------------------------------------------

  // five-bit setting at 0FH; values above the legal maximum are
  // clamped so a stray write cannot push the counter past its width
  logic [SET_W-1:0] setWritten;
  assign setWritten = (ioReq.data[SET_W-1:0] > SET_MAX) ? SET_MAX
                                                        : ioReq.data[SET_W-1:0];
  assign debounceSet_nxt = wrDebounce ? setWritten : debounceSet_r;

  // setting clears at reset, filter starts disabled
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      debounceSet_r <= SET_RESET;
    end else begin
      debounceSet_r <= debounceSet_nxt;
    end
  end

  // ---------------------------------------------------------------
  // 16 MHz time base
  // ---------------------------------------------------------------

  // fractional accumulator gives 16 ticks per 200 clocks, so each
  // tick is 12.5 clocks on average; jitter is one clock per tick
  assign tbSum     = tbAcc_r + TB_STEP;
  assign tbTick    = (tbSum >= TB_MOD);
  assign tbAcc_nxt = tbTick ? (tbSum - TB_MOD) : tbSum;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tbAcc_r <= '0;
    end else begin
      tbAcc_r <= tbAcc_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Input filter
  // ---------------------------------------------------------------

  // one setting and one tick feed every channel alike
  gioif_filter uFilter (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .tick      (tbTick),
    .setting   (debounceSet_r),
    .pinLevel  (inPinLevel),
    .filtLevel (filtLevel)
  );

  // a low (on) pin reads as one
  assign inBits = ~filtLevel;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Byte of any group by number; groups four to seven are the latches
  function automatic logic [GROUP_W-1:0] groupByte(
    input logic [PTR_W-1:0]   g,
    input logic [IN_W-1:0]    ins,
    input logic [OUT_W-1:0]   outs
  );
    logic [GROUP_W-1:0] b;
    b = READ_ZERO;
    // group g is byte g; upper half reads back the latches
    if (g[PTR_OUT_BIT]) begin
      b = outs[g[1:0]*GROUP_W +: GROUP_W];
    end else begin
      b = ins[g[1:0]*GROUP_W +: GROUP_W];
    end
    return b;
  endfunction

  // Flat view of the output latches for the read mux
  logic [OUT_W-1:0] outFlat;
  generate
    for (og = 0; og < OUT_GROUPS; og++) begin : gFlat
      assign outFlat[og*GROUP_W +: GROUP_W] = outLatch_r[og];
    end
  endgenerate

  // Candidate read bytes
  logic [GROUP_W-1:0] directByte;
  logic [GROUP_W-1:0] pointedByte;
  logic [GROUP_W-1:0] debounceByte;

  assign directByte   = groupByte(directGroup, inBits, outFlat);
  // group value port follows the current pointer
  assign pointedByte  = groupByte(groupPtr_r, inBits, outFlat);
  // setting reads back as stored after clamping, upper bits zero
  assign debounceByte = {{(GROUP_W-SET_W){1'b0}}, debounceSet_r};

  // Pointer port is write-only and unmapped bytes read zero
  always_comb begin
    if (hitInGroup || hitOutGroup) begin
      rdData_nxt = directByte;
    end else if (hitGroupValue) begin
      rdData_nxt = pointedByte;
    end else if (hitDebounce) begin
      rdData_nxt = debounceByte;
    end else begin
      rdData_nxt = READ_ZERO;
    end
  end

  // Answer is registered, one clock after the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdData_r  <= READ_ZERO;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= ioReq.rd;
      if (ioReq.rd) begin
        rdData_r <= rdData_nxt;
      end
    end
  end

  assign ioRdData  = rdData_r;
  assign ioRdValid = rdValid_r;

endmodule
